// >>> common/dma_addr_params.svh
// Register offsets, field positions and reset values of the DMA address block.
// Assumes inclusion by bare name from the design files and the bench.
`ifndef DMA_ADDR_PARAMS_SVH
`define DMA_ADDR_PARAMS_SVH

// --------------------------------------------------------------------------
// Channel 0 register byte offsets
// --------------------------------------------------------------------------
`define OFS_CH0_SRC_HIGH   12'h520
`define OFS_CH0_SRC_LOW    12'h524
`define OFS_CH0_DST_HIGH   12'h528
`define OFS_CH0_DST_LOW    12'h52c
`define OFS_CH0_SRC_ATTR   12'h530
// --------------------------------------------------------------------------
// Channel 1 register byte offsets
// --------------------------------------------------------------------------
`define OFS_CH1_SRC_HIGH   12'h5a0
`define OFS_CH1_SRC_LOW    12'h5a4
`define OFS_CH1_DST_HIGH   12'h5a8
`define OFS_CH1_DST_LOW    12'h5ac
`define OFS_CH1_SRC_ATTR   12'h5b0
// --------------------------------------------------------------------------
// Mode control and status registers
// --------------------------------------------------------------------------
`define OFS_MODE_CTRL      12'h5f0
`define OFS_MODE_STATUS    12'h5f4
`define ADDR_WIDTH         12
// --------------------------------------------------------------------------
// Source attribute fields
// --------------------------------------------------------------------------
`define ATTR_TYPE_HI       29
`define ATTR_TYPE_LO       28
`define ATTR_PSZ_BIT       25
`define ATTR_NIP_BIT       24
`define ATTR_SSTM_HI       12
`define ATTR_SSTM_LO       11
`define ATTR_TM_HI         10
`define ATTR_TM_LO         8
`define ATTR_VME_HI        7
`define ATTR_VME_LO        0
`define ATTR_WRITE_MASK    32'h330_01fff
`define ATTR_VME_MASK      32'h0000_1fff
`define ATTR_PAT_MASK      32'h0300_0000
`define ATTR_TYPE_MASK     32'h3000_0000
// --------------------------------------------------------------------------
// Reset values and responses
// --------------------------------------------------------------------------
`define REG_RESET          32'h0000_0000
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2
`endif

// >>> common/dma_addr_pkg.sv
// Types shared by the DMA address register block.
// Assumes nothing beyond a SystemVerilog compiler.
package dma_addr_pkg;
  typedef enum logic [1:0]
  {
    SPACE_PCIX,
    SPACE_VME,
    SPACE_PATTERN
  } space_t;
  typedef logic [31:0] word_t;
  typedef logic [63:0] addr_t;
endpackage : dma_addr_pkg

// >>> src/dma_chan_regs.sv
// One channel's address and source attribute registers.
// Assumes write strobes and descriptor load from the bus slave on the same clock.
`include "dma_addr_params.svh"

module dma_chan_regs
(
  input  wire logic                clk,
  input  wire logic                rstn,
  input  wire logic [3:0]          wr_en,
  input  wire logic                attr_wr,
  input  wire logic [31:0]         wr_data,
  input  wire logic [3:0]          wr_strb,
  input  wire logic                desc_load,
  input  wire logic [63:0]         desc_src,
  input  wire logic [63:0]         desc_dst,
  input  wire logic [31:0]         desc_attr,
  output logic      [31:0]         src_high_q,
  output logic      [31:0]         src_low_q,
  output logic      [31:0]         dst_high_q,
  output logic      [31:0]         dst_low_q,
  output logic      [31:0]         attr_q,
  output dma_addr_pkg::space_t     src_space,
  output logic      [31:0]         attr_eff
);

  logic [31:0] byte_mask;

  // ------------------------------------------------------------------------
  // Byte lane mask
  // ------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_lane
      assign byte_mask[g*8 +: 8] = {8{wr_strb[g]}};
    end
  endgenerate

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v);
    merge = (old_v & ~byte_mask) | (new_v & byte_mask);
  endfunction : merge

  // ------------------------------------------------------------------------
  // Address registers
  // ------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      src_high_q <= `REG_RESET;
      src_low_q  <= `REG_RESET;
      dst_high_q <= `REG_RESET;
      dst_low_q  <= `REG_RESET;
    end
    else if (desc_load)
    begin
      src_high_q <= desc_src[63:32];
      src_low_q  <= desc_src[31:0];
      dst_high_q <= desc_dst[63:32];
      dst_low_q  <= desc_dst[31:0];
    end
    else
    begin
      if (wr_en[0])
        src_high_q <= merge(src_high_q, wr_data);
      if (wr_en[1])
        src_low_q <= merge(src_low_q, wr_data);
      if (wr_en[2])
        dst_high_q <= merge(dst_high_q, wr_data);
      if (wr_en[3])
        dst_low_q <= merge(dst_low_q, wr_data);
    end
  end

  // ------------------------------------------------------------------------
  // Source attribute register
  // ------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      attr_q <= `REG_RESET;
    else if (desc_load)
      attr_q <= desc_attr & `ATTR_WRITE_MASK;
    else if (attr_wr)
      attr_q <= merge(attr_q, wr_data) & `ATTR_WRITE_MASK;
  end

  // ------------------------------------------------------------------------
  // Source type decode and field gating
  // ------------------------------------------------------------------------
  always_comb
  begin
    if (attr_q[`ATTR_TYPE_HI])
      src_space = dma_addr_pkg::SPACE_PATTERN;
    else if (attr_q[`ATTR_TYPE_LO])
      src_space = dma_addr_pkg::SPACE_VME;
    else
      src_space = dma_addr_pkg::SPACE_PCIX;
  end

  always_comb
  begin
    unique case (src_space)
      dma_addr_pkg::SPACE_VME:     attr_eff = attr_q & (`ATTR_VME_MASK | `ATTR_TYPE_MASK);
      dma_addr_pkg::SPACE_PATTERN: attr_eff = attr_q & (`ATTR_PAT_MASK | `ATTR_TYPE_MASK);
      default:                     attr_eff = attr_q & `ATTR_TYPE_MASK;
    endcase
  end

  // ------------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------------
  sequence desc_seen_s;
    desc_load;
  endsequence

  property desc_src_p;
    @(posedge clk) disable iff (!rstn) desc_seen_s |=> {src_high_q, src_low_q} == $past(desc_src);
  endproperty

  desc_src_load_a: assert property (desc_src_p)
    else $error("Source address not loaded from descriptor");

  desc_dst_load_a: assert property (@(posedge clk) disable iff (!rstn)
    desc_load |=> {dst_high_q, dst_low_q} == $past(desc_dst))
    else $error("Destination address not loaded from descriptor");

  desc_attr_load_a: assert property (@(posedge clk) disable iff (!rstn)
    desc_load |=> attr_q == ($past(desc_attr) & `ATTR_WRITE_MASK))
    else $error("Attribute not loaded from descriptor");

  src_high_wr_a: assert property (@(posedge clk) disable iff (!rstn)
    (wr_en[0] && !desc_load && wr_strb == 4'hf) |=> src_high_q == $past(wr_data))
    else $error("Source high word write lost");

  src_low_wr_a: assert property (@(posedge clk) disable iff (!rstn)
    (wr_en[1] && !desc_load && wr_strb == 4'hf) |=> src_low_q == $past(wr_data))
    else $error("Source low word write lost");

  dst_high_wr_a: assert property (@(posedge clk) disable iff (!rstn)
    (wr_en[2] && !desc_load && wr_strb == 4'hf) |=> dst_high_q == $past(wr_data))
    else $error("Destination high word write lost");

  dst_low_wr_a: assert property (@(posedge clk) disable iff (!rstn)
    (wr_en[3] && !desc_load && wr_strb == 4'hf) |=> dst_low_q == $past(wr_data))
    else $error("Destination low word write lost");

  addr_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    (wr_en == 4'h0 && !desc_load) |=> $stable({src_high_q, src_low_q, dst_high_q, dst_low_q}))
    else $error("Address changed without a write");

  pattern_type_a: assert property (@(posedge clk) disable iff (!rstn)
    attr_q[`ATTR_TYPE_HI] |-> (src_space == dma_addr_pkg::SPACE_PATTERN && attr_eff[`ATTR_VME_HI:0] == 8'h00))
    else $error("Pattern source decode wrong");

endmodule : dma_chan_regs

// >>> src/dma_channel_address_regs.sv
// Two-channel DMA address and source attribute register block, AXI4-Lite slave.
// Assumes one clock; descriptor loads come from a fetch engine on the same clock.
//
// Notes on behaviour
// - Each channel holds source address bits 63:32 in a high register.
// - Each channel holds source address bits 31:0 in a low register.
// - Each channel holds destination address bits 63:32 in a high register.
// - Each channel holds destination address bits 31:0 in a low register.
// - The source address is presented as a VMEbus or PCI/X address by source space.
// - The destination address is presented as a VMEbus or PCI/X address by destination space.
// - In chain mode the source address registers load from the current descriptor.
// - In chain mode the destination address registers load from the current descriptor.
// - In chain mode the source attribute loads from the current descriptor.
// - Attribute fields that do not apply to the source type have no effect.
// - Source type 00b selects PCI/X, 01b VMEbus and 1xb a data pattern.
//
// Added by the designer: register access over AXI4-Lite.
`include "dma_addr_params.svh"

module dma_channel_address_regs
(
  input  wire logic                     clk,
  input  wire logic                     rstn,
  input  wire logic [`ADDR_WIDTH-1:0]   s_axi_awaddr,
  input  wire logic [2:0]               s_axi_awprot,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [`ADDR_WIDTH-1:0]   s_axi_araddr,
  input  wire logic [2:0]               s_axi_arprot,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  input  wire logic [1:0]               desc_load,
  input  wire logic [63:0]              desc_src,
  input  wire logic [63:0]              desc_dst,
  input  wire logic [31:0]              desc_attr,
  input  wire logic [1:0]               dst_is_vme,
  output logic [127:0]                  src_addr,
  output logic [127:0]                  dst_addr,
  output logic [3:0]                    src_space,
  output logic [63:0]                   src_attr,
  output logic [1:0]                    src_to_vme,
  output logic [1:0]                    src_to_pcix,
  output logic [1:0]                    dst_to_vme,
  output logic [1:0]                    dst_to_pcix,
  output logic [1:0]                    chain_mode
);

  logic [`ADDR_WIDTH-1:0] aw_addr_q;
  logic                   aw_held_q;
  logic [31:0]            w_data_q;
  logic [3:0]             w_strb_q;
  logic                   w_held_q;
  logic                   wr_fire;
  logic                   wr_hit;
  logic [3:0]             wr_en     [2];
  logic [1:0]             attr_wr;
  logic [1:0]             mode_q;
  logic [31:0]            rd_word;
  logic                   rd_hit;
  logic [31:0]            r_src_high [2];
  logic [31:0]            r_src_low  [2];
  logic [31:0]            r_dst_high [2];
  logic [31:0]            r_dst_low  [2];
  logic [31:0]            r_attr     [2];
  logic [31:0]            r_eff      [2];
  dma_addr_pkg::space_t   r_space    [2];

  // --------------------------------------------------------------------------
  // Write address and data capture, either order
  // --------------------------------------------------------------------------
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
  assign wr_fire       = aw_held_q && w_held_q && !s_axi_bvalid;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end
    else if (wr_fire)
      aw_held_q <= 1'b0;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      w_held_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end
    else if (wr_fire)
      w_held_q <= 1'b0;
  end

  // --------------------------------------------------------------------------
  // Write decode
  // --------------------------------------------------------------------------
  always_comb
  begin
    wr_en[0] = 4'h0;
    wr_en[1] = 4'h0;
    attr_wr  = 2'h0;
    wr_hit   = 1'b1;
    if (wr_fire)
    begin
      unique case (aw_addr_q)
        `OFS_CH0_SRC_HIGH: wr_en[0] = 4'h1;
        `OFS_CH0_SRC_LOW:  wr_en[0] = 4'h2;
        `OFS_CH0_DST_HIGH: wr_en[0] = 4'h4;
        `OFS_CH0_DST_LOW:  wr_en[0] = 4'h8;
        `OFS_CH0_SRC_ATTR: attr_wr[0] = 1'b1;
        `OFS_CH1_SRC_HIGH: wr_en[1] = 4'h1;
        `OFS_CH1_SRC_LOW:  wr_en[1] = 4'h2;
        `OFS_CH1_DST_HIGH: wr_en[1] = 4'h4;
        `OFS_CH1_DST_LOW:  wr_en[1] = 4'h8;
        `OFS_CH1_SRC_ATTR: attr_wr[1] = 1'b1;
        `OFS_MODE_CTRL:    wr_hit = 1'b1;
        default:           wr_hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      mode_q <= 2'h0;
    else if (wr_fire && aw_addr_q == `OFS_MODE_CTRL && w_strb_q[0])
      mode_q <= w_data_q[1:0];
  end

  assign chain_mode = mode_q;

  // --------------------------------------------------------------------------
  // Write response
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // --------------------------------------------------------------------------
  // Channel register sets
  // --------------------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < 2; c++)
    begin : g_chan
      dma_chan_regs u_regs
      (
        .clk        (clk),
        .rstn       (rstn),
        .wr_en      (wr_en[c]),
        .attr_wr    (attr_wr[c]),
        .wr_data    (w_data_q),
        .wr_strb    (w_strb_q),
        .desc_load  (desc_load[c] && mode_q[c]),
        .desc_src   (desc_src),
        .desc_dst   (desc_dst),
        .desc_attr  (desc_attr),
        .src_high_q (r_src_high[c]),
        .src_low_q  (r_src_low[c]),
        .dst_high_q (r_dst_high[c]),
        .dst_low_q  (r_dst_low[c]),
        .attr_q     (r_attr[c]),
        .src_space  (r_space[c]),
        .attr_eff   (r_eff[c])
      );
      assign src_addr[c*64 +: 64]  = {r_src_high[c], r_src_low[c]};
      assign dst_addr[c*64 +: 64]  = {r_dst_high[c], r_dst_low[c]};
      assign src_space[c*2 +: 2]   = r_space[c];
      assign src_attr[c*32 +: 32]  = r_eff[c];
      assign src_to_vme[c]  = (r_space[c] == dma_addr_pkg::SPACE_VME);
      assign src_to_pcix[c] = (r_space[c] == dma_addr_pkg::SPACE_PCIX);
      assign dst_to_vme[c]  = dst_is_vme[c];
      assign dst_to_pcix[c] = !dst_is_vme[c];
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  always_comb
  begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (s_axi_araddr)
      `OFS_CH0_SRC_HIGH: rd_word = r_src_high[0];
      `OFS_CH0_SRC_LOW:  rd_word = r_src_low[0];
      `OFS_CH0_DST_HIGH: rd_word = r_dst_high[0];
      `OFS_CH0_DST_LOW:  rd_word = r_dst_low[0];
      `OFS_CH0_SRC_ATTR: rd_word = r_attr[0];
      `OFS_CH1_SRC_HIGH: rd_word = r_src_high[1];
      `OFS_CH1_SRC_LOW:  rd_word = r_src_low[1];
      `OFS_CH1_DST_HIGH: rd_word = r_dst_high[1];
      `OFS_CH1_DST_LOW:  rd_word = r_dst_low[1];
      `OFS_CH1_SRC_ATTR: rd_word = r_attr[1];
      `OFS_MODE_CTRL:    rd_word = {30'h0, mode_q};
      `OFS_MODE_STATUS:  rd_word = {28'h0, r_space[1], r_space[0]};
      default:           rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  sequence wr_done_s;
    wr_fire ##1 s_axi_bvalid;
  endsequence

  wr_resp_a: assert property (@(posedge clk) disable iff (!rstn)
    wr_fire |-> ##1 s_axi_bvalid)
    else $error("Write response missing");

  chan_isolate_a: assert property (@(posedge clk) disable iff (!rstn)
    (wr_en[0] != 4'h0 && !desc_load[1]) |=> $stable(src_addr[127:64]) && $stable(dst_addr[127:64]))
    else $error("Channel 0 write disturbed channel 1");

  chan1_isolate_a: assert property (@(posedge clk) disable iff (!rstn)
    (wr_en[1] != 4'h0 && !desc_load[0]) |=> $stable(src_addr[63:0]) && $stable(dst_addr[63:0]))
    else $error("Channel 1 write disturbed channel 0");

  src_space_a: assert property (@(posedge clk) disable iff (!rstn)
    !(src_to_vme[0] && src_to_pcix[0]) && !(src_to_vme[1] && src_to_pcix[1]))
    else $error("Source space decode overlaps");

  field_gate_a: assert property (@(posedge clk) disable iff (!rstn)
    (src_space[1:0] != 2'h1 |-> src_attr[12:0] == 13'h0) and
    (src_space[3:2] != 2'h1 |-> src_attr[44:32] == 13'h0))
    else $error("Inapplicable attribute field passed on");

  space_code_a: assert property (@(posedge clk) disable iff (!rstn)
    src_space[1:0] != 2'h3 && src_space[3:2] != 2'h3)
    else $error("Source space code out of range");

  resp_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    wr_done_s ##0 !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped before bready");

  wr_err_a: assert property (@(posedge clk) disable iff (!rstn)
    (wr_fire && !wr_hit) |=> s_axi_bresp == `RESP_SLVERR)
    else $error("Unmapped write not refused");

  mode_wr_a: assert property (@(posedge clk) disable iff (!rstn)
    (wr_fire && aw_addr_q == `OFS_MODE_CTRL && w_strb_q[0]) |=> chain_mode == $past(w_data_q[1:0]))
    else $error("Mode control write lost");

  rd_resp_a: assert property (@(posedge clk) disable iff (!rstn)
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid && s_axi_rdata == $past(rd_word))
    else $error("Read answer missing");

  rd_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("Read answer dropped before rready");

  rd_err_a: assert property (@(posedge clk) disable iff (!rstn)
    (s_axi_arvalid && s_axi_arready && !rd_hit) |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("Unmapped read not refused");

endmodule : dma_channel_address_regs

// >>> bench/tb.sv
// Self-checking bench for the two-channel DMA address register block.
// Assumes the design's AXI4-Lite slave and the shared offset header.
`include "dma_addr_params.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk, rstn, awvalid, wvalid, bready, arvalid, rready;
  logic [11:0]  awaddr, araddr;
  logic [31:0]  wdata, desc_attr, seed, av;
  logic [3:0]   wstrb, src_space;
  logic [1:0]   desc_load, dst_is_vme, bresp, rresp, src_to_vme, src_to_pcix, dst_to_vme, dst_to_pcix, chain_mode;
  logic         awready, wready, bvalid, arready, rvalid;
  logic [31:0]  rdata, rd, m [8];
  logic [63:0]  desc_src, desc_dst, src_attr;
  logic [127:0] src_addr, dst_addr;
  logic [1:0]   rsp;
  int           mismatches, comparisons;
  logic [11:0]  ofs [8] = '{`OFS_CH0_SRC_HIGH, `OFS_CH0_SRC_LOW, `OFS_CH0_DST_HIGH, `OFS_CH0_DST_LOW,
                          `OFS_CH1_SRC_HIGH, `OFS_CH1_SRC_LOW, `OFS_CH1_DST_HIGH, `OFS_CH1_DST_LOW};

  dma_channel_address_regs u_dma_channel_address_regs
  (
    .clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .desc_load(desc_load), .desc_src(desc_src), .desc_dst(desc_dst), .desc_attr(desc_attr),
    .dst_is_vme(dst_is_vme), .src_addr(src_addr), .dst_addr(dst_addr), .src_space(src_space),
    .src_attr(src_attr), .src_to_vme(src_to_vme), .src_to_pcix(src_to_pcix), .dst_to_vme(dst_to_vme),
    .dst_to_pcix(dst_to_pcix), .chain_mode(chain_mode)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // Attribute with fields that do not apply to its source type cleared
  function automatic logic [31:0] eff_attr(input logic [31:0] a);
    logic [31:0] keep;
    keep = 32'h3000_0000 | ((a[29:28] == 2'h1) ? 32'h0000_1fff : (a[29] ? 32'h0300_0000 : 32'h0));
    return a & 32'h3300_1fff & keep;
  endfunction : eff_attr

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_word

  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_resp

  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_hs, w_hs, b_hs;
    int   n;
    @(posedge clk);
    awaddr <= a; wdata <= d; wstrb <= 4'hf; awvalid <= 1'b1; wvalid <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(negedge clk);
      aw_hs = awvalid && awready;
      w_hs  = wvalid && wready;
      b_hs  = bvalid && bready;
      r     = bresp;
      @(posedge clk);
      if (aw_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
      if (b_hs)
      begin
        bready <= 1'b0;
        return;
      end
      bready <= (n > 1);
    end
    mismatches++;
    wrap_up();
  endtask : axi_write

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_hs, r_hs;
    int   n;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(negedge clk);
      ar_hs = arvalid && arready;
      r_hs  = rvalid && rready;
      d     = rdata;
      r     = rresp;
      @(posedge clk);
      if (ar_hs) arvalid <= 1'b0;
      if (r_hs)
      begin
        rready <= 1'b0;
        return;
      end
      rready <= (n > 0);
    end
    mismatches++;
    wrap_up();
  endtask : axi_read

  // Reads every address register back and checks the address outputs
  task automatic check_all();
    for (int i = 0; i < 8; i++)
    begin
      axi_read(ofs[i], rd, rsp);
      cmp_word(rd, m[i]);
      cmp_resp(rsp, `RESP_OKAY);
    end
    @(negedge clk);
    for (int c = 0; c < 2; c++)
    begin
      cmp_word(src_addr[64*c+32 +: 32], m[4*c]);
      cmp_word(src_addr[64*c +: 32], m[4*c+1]);
      cmp_word(dst_addr[64*c+32 +: 32], m[4*c+2]);
      cmp_word(dst_addr[64*c +: 32], m[4*c+3]);
    end
  endtask : check_all

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial
  begin
    seed = 32'hcfdd;
    rstn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    awaddr = 12'h0; araddr = 12'h0; wdata = 32'h0; wstrb = 4'h0; desc_load = 2'h0;
    desc_src = 64'h0; desc_dst = 64'h0; desc_attr = 32'h0; dst_is_vme = 2'h0;
    mismatches = 0; comparisons = 0;
    foreach (m[i]) m[i] = 32'h0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    check_all();
    $display("test reset done");
    for (int k = 0; k < 4; k++)
    begin
      for (int i = 0; i < 8; i++)
      begin
        m[i] = (k == 0) ? 32'hffff_ffff : xs();
        axi_write(ofs[i], m[i], rsp);
        cmp_resp(rsp, `RESP_OKAY);
      end
      check_all();
    end
    $display("test address registers done");
    axi_write(12'h700, 32'h1234_5678, rsp);
    cmp_resp(rsp, `RESP_SLVERR);
    axi_read(12'h700, rd, rsp);
    cmp_resp(rsp, `RESP_SLVERR);
    check_all();
    $display("test unmapped done");
    for (int c = 0; c < 2; c++)
      for (int t = 0; t < 4; t++)
      begin
        av = xs();
        av[29:28] = t[1:0];
        axi_write(c ? `OFS_CH1_SRC_ATTR : `OFS_CH0_SRC_ATTR, av, rsp);
        axi_read(c ? `OFS_CH1_SRC_ATTR : `OFS_CH0_SRC_ATTR, rd, rsp);
        cmp_word(rd, av & 32'h3300_1fff);
        @(posedge clk);
        dst_is_vme <= 2'(xs());
        @(negedge clk);
        cmp_word(src_attr[32*c +: 32], eff_attr(av));
        cmp_resp(src_space[2*c +: 2], t[1] ? 2'h2 : t[1:0]);
        cmp_resp({src_to_vme[c], src_to_pcix[c]}, {t == 1, t == 0});
        cmp_resp({dst_to_vme[c], dst_to_pcix[c]}, {dst_is_vme[c], !dst_is_vme[c]});
        axi_read(`OFS_MODE_STATUS, rd, rsp);
        cmp_resp(rd[2*c +: 2], t[1] ? 2'h2 : t[1:0]);
      end
    $display("test attributes done");
    for (int k = 0; k < 4; k++)
    begin
      axi_write(`OFS_MODE_CTRL, {30'h0, k[1:0]}, rsp);
      cmp_resp(rsp, `RESP_OKAY);
      cmp_resp(chain_mode, k[1:0]);
      @(posedge clk);
      desc_src <= {xs(), xs()};
      desc_dst <= {xs(), xs()};
      desc_attr <= xs();
      desc_load <= 2'h3;
      @(posedge clk);
      desc_load <= 2'h0;
      for (int c = 0; c < 2; c++)
        if (k[c])
        begin
          m[4*c] = desc_src[63:32]; m[4*c+1] = desc_src[31:0];
          m[4*c+2] = desc_dst[63:32]; m[4*c+3] = desc_dst[31:0];
          axi_read(c ? `OFS_CH1_SRC_ATTR : `OFS_CH0_SRC_ATTR, rd, rsp);
          cmp_word(rd, desc_attr & 32'h3300_1fff);
        end
      check_all();
    end
    $display("test descriptor load done");
    wrap_up();
  end

  initial
  begin
    #500us;
    mismatches++;
    wrap_up();
  end
endmodule : tb
